/* File: dcf_fifo.sv */
// Flagged FIFO with standard and fall-through timing, offset
// programming, two resets and retransmit. Wishbone status port.
// Assumes the FIFO-side pins are asynchronous to clk and change slower than clk/4; Wishbone is synchronous to clk.
//
// Behaviour
// [RULE1] Store 9-bit words, 262,144 or 524,288 deep by parameter.
// [RULE2] Write clock rise with write enable stores the input word.
// [RULE3] Read clock rise with read enable performs one read.
// [RULE4] Write and read clocks are independent of each other.
// [RULE5] Output enable high floats the data outputs, low drives them.
// [RULE6] Standard mode: first word appears only after a read.
// [RULE7] Fall-through: first word appears after three read clock transitions.
// [RULE8] Fall-through: later words need read enable low at a clock edge.
// [RULE9] Mode pin level during full reset selects the timing mode.
// [RULE10] Fall-through outputs chain into a next FIFO without glue.
// [RULE11] Shared flags: empty/full in standard, ready flags in fall-through.
// [RULE12] Near-empty and near-full thresholds set by separate offsets.
// [RULE13] Default offsets 127 or 1,023 from each boundary.
// [RULE14] Serial enable plus load shifts one bit per write clock.
// [RULE15] Write enable plus load takes offset data from the inputs.
// [RULE16] Read enable plus load shows offsets on the data outputs.
// [RULE17] Full reset returns both pointers to the first location.
// [RULE18] Load pin at full reset: 127 parallel or 1,023 serial.
// [RULE19] After full reset flags follow mode and default offsets.
// [RULE20] Pointer reset clears pointers, keeps mode, method and offsets.
// [RULE21] Low rewind at read clock rise resets the read pointer.
// [RULE22] Rewind keeps write side and settings, forces empty briefly.
// [RULE23] Both resets clear the output register to zero.
// [RULE24] Near-full low when count exceeds capacity minus full offset.
// [RULE25] Near-empty low when count is below empty offset.
// [RULE26] Writes when full and reads when empty are ignored.
// [RULE27] Flags derived from safely synchronised pointers.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns
module dcf_fifo #(
   parameter int DEPTH_LOG2 = dcf_pkg::DEPTH_LOG2_DEF
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wclk,
   input wire logic rclk,
   input wire logic write_en_n,
   input wire logic read_en_n,
   input wire logic full_reset_n,
   input wire logic pointer_reset_n,
   input wire logic rewind_read_n,
   input wire logic mode_select_serial_in,
   input wire logic offset_access_n,
   input wire logic serial_load_enable_n,
   input wire logic out_en_n,
   input wire logic [dcf_pkg::DATA_W-1:0] write_data_in,
   output logic [dcf_pkg::DATA_W-1:0] read_data_out,
   output logic read_data_oe_n,
   output logic empty_or_out_ready,
   output logic full_or_in_ready,
   output logic half_level_flag_n,
   output logic near_empty_flag_n,
   output logic near_full_flag_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import dcf_pkg::*;

   localparam int AW = DEPTH_LOG2;
   localparam int OW = DEPTH_LOG2;
   localparam int PARTS = (OW + DATA_W - 1) / DATA_W;
   localparam int PW = PARTS * DATA_W;
   localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
   localparam logic [AW:0] HALF = {2'b01, {(AW-1){1'b0}}};
   // Synchronisers wake at idle pin levels, so reset_n fakes no pin reset
   localparam dcf_pins_t PINS_IDLE = '{write_en_n: 1'b1, read_en_n: 1'b1,
      full_reset_n: 1'b1, pointer_reset_n: 1'b1, rewind_read_n: 1'b1,
      offset_access_n: 1'b1, serial_load_enable_n: 1'b1, out_en_n: 1'b1, default: '0};

   typedef struct packed {
      dcf_pins_t s1;
      dcf_pins_t s2;
      logic wclk_q;
      logic rclk_q;
      logic [AW:0] wptr;
      logic [AW:0] rptr;
      logic [OW-1:0] eofs;
      logic [OW-1:0] fofs;
      logic fall_through_mode;
      logic serial;
      logic [2:0] wstep;
      logic [2:0] rstep;
      logic [2:0] ft_cnt;
      logic valid;
      logic retx;
      logic [DATA_W-1:0] dout;
      logic oe_n;
      logic eor;
      logic fir;
      logic hf_n;
      logic pae_n;
      logic paf_n;
      logic ack;
      logic [31:0] rdat;
   } dcf_state_t;

   dcf_state_t st_reg;
   dcf_state_t st_next;
   dcf_pins_t pins;
   dcf_pins_t sp;
   logic [DATA_W-1:0] mem [0:(1<<AW)-1];
   logic [DATA_W-1:0] mem_rd;
   logic [AW:0] cnt;
   logic full;
   logic empty;
   logic wrise;
   logic rrise;
   logic rtog;
   logic wr_fire;
   logic in_reset;

   // -------------------------------------------------------
   // Helpers
   // -------------------------------------------------------
   function automatic logic [DATA_W-1:0] get_part(input logic [OW-1:0] o,
                                                  input logic [2:0] i);
      logic [PW-1:0] w;
      w = PW'(o);
      return w[i*DATA_W +: DATA_W];
   endfunction

   function automatic logic [OW-1:0] set_part(input logic [OW-1:0] o,
                                              input logic [2:0] i,
                                              input logic [DATA_W-1:0] d);
      logic [PW-1:0] w;
      w = PW'(o);
      w[i*DATA_W +: DATA_W] = d;
      return w[OW-1:0];
   endfunction

   function automatic logic [2:0] part_idx(input logic [2:0] step);
      return (step < 3'(PARTS)) ? step : step - 3'(PARTS);
   endfunction

   function automatic logic [OW-1:0] wb_merge(input logic [OW-1:0] o,
                                              input logic [31:0] d,
                                              input logic [3:0] sel);
      logic [31:0] m;
      m = 32'(o);
      for (int i = 0; i < BUS_BYTES; i++) begin
         if (sel[i]) begin
            m[i*BYTE_W +: BYTE_W] = d[i*BYTE_W +: BYTE_W];
         end
      end
      return m[OW-1:0];
   endfunction

   // -------------------------------------------------------
   // Memory
   // -------------------------------------------------------
   // Kept outside the state struct: no reset, so it maps to RAM
   always_ff @(posedge clk) begin
      if (wr_fire) begin
         mem[st_reg.wptr[AW-1:0]] <= sp.write_data_in; // [RULE1] [RULE2]
      end
   end
   assign mem_rd = mem[st_reg.rptr[AW-1:0]];

   assign pins = {wclk, rclk, write_en_n, read_en_n, full_reset_n,
                  pointer_reset_n, rewind_read_n, mode_select_serial_in,
                  offset_access_n, serial_load_enable_n, out_en_n,
                  write_data_in};
   assign sp = st_reg.s2;
   // Both FIFO clocks are seen as edges of sampled pins [RULE4]
   assign wrise = sp.wclk & ~st_reg.wclk_q;
   assign rrise = sp.rclk & ~st_reg.rclk_q;
   assign rtog = sp.rclk ^ st_reg.rclk_q;
   assign cnt = st_reg.wptr - st_reg.rptr;
   assign full = (cnt == DEPTH);
   assign empty = (cnt == '0);
   assign in_reset = ~sp.full_reset_n | ~sp.pointer_reset_n;
   assign wr_fire = wrise & ~sp.write_en_n & sp.offset_access_n & ~full
                    & ~in_reset; // [RULE26]

   // -------------------------------------------------------
   // Next state
   // -------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pins;
      st_next.s2 = st_reg.s1;
      st_next.wclk_q = sp.wclk;
      st_next.rclk_q = sp.rclk;
      st_next.oe_n = sp.out_en_n; // [RULE5]

      // Offset programming on the write clock
      if (wrise & ~sp.offset_access_n) begin
         if (!st_reg.serial & ~sp.write_en_n) begin
            if (st_reg.wstep < 3'(PARTS)) begin
               st_next.eofs = set_part(st_reg.eofs, part_idx(st_reg.wstep),
                                       sp.write_data_in); // [RULE15]
            end else begin
               st_next.fofs = set_part(st_reg.fofs, part_idx(st_reg.wstep),
                                       sp.write_data_in); // [RULE15]
            end
            st_next.wstep = (st_reg.wstep == 3'(2*PARTS-1)) ? '0 : st_reg.wstep + 3'd1;
         end else if (st_reg.serial & ~sp.serial_load_enable_n) begin
            // Empty offset fills first, LSB first
            {st_next.fofs, st_next.eofs} = {sp.mode_select_serial_in,
                                            st_reg.fofs, st_reg.eofs[OW-1:1]}; // [RULE14]
         end
      end
      if (wr_fire) begin
         st_next.wptr = st_reg.wptr + 1'b1; // [RULE2]
      end

      // Read side
      if (rrise & st_reg.retx & sp.rewind_read_n) begin
         st_next.retx = 1'b0;
      end
      if (rrise & ~sp.rewind_read_n) begin
         st_next.rptr = '0; // [RULE21]
         st_next.valid = 1'b0;
         st_next.ft_cnt = '0;
         st_next.retx = 1'b1; // [RULE22]
      end else if (rrise & ~sp.read_en_n & ~sp.offset_access_n) begin
         st_next.dout = get_part(st_reg.rstep < 3'(PARTS) ? st_reg.eofs : st_reg.fofs,
                                 part_idx(st_reg.rstep)); // [RULE16]
         st_next.rstep = (st_reg.rstep == 3'(2*PARTS-1)) ? '0 : st_reg.rstep + 3'd1;
      end else if (!st_reg.fall_through_mode) begin
         if (rrise & ~sp.read_en_n & ~empty) begin
            st_next.dout = mem_rd; // [RULE3] [RULE6] [RULE26]
            st_next.rptr = st_reg.rptr + 1'b1;
         end
      end else if (st_reg.valid) begin
         if (rrise & ~sp.read_en_n) begin
            if (!empty) begin
               st_next.dout = mem_rd; // [RULE8] [RULE10]
               st_next.rptr = st_reg.rptr + 1'b1;
            end else begin
               st_next.valid = 1'b0;
            end
         end
      end else if (!empty & rtog) begin
         // First word falls through with no read enable
         if (st_reg.ft_cnt == 3'(FT_TRANS-1)) begin
            st_next.dout = mem_rd; // [RULE7]
            st_next.rptr = st_reg.rptr + 1'b1;
            st_next.valid = 1'b1;
            st_next.ft_cnt = '0;
         end else begin
            st_next.ft_cnt = st_reg.ft_cnt + 3'd1;
         end
      end

      // Flags; all pointers live in clk, so no gray crossing is needed [RULE27]
      st_next.eor = st_reg.fall_through_mode ? ~st_reg.valid : ~(empty | st_reg.retx); // [RULE11]
      st_next.fir = ~(full ^ st_reg.fall_through_mode); // [RULE11]
      st_next.hf_n = ~(cnt > HALF);
      st_next.pae_n = ~(cnt < {1'b0, st_reg.eofs}); // [RULE12] [RULE25]
      st_next.paf_n = ~(cnt > DEPTH - {1'b0, st_reg.fofs}); // [RULE12] [RULE24]

      // Wishbone slave: one wait state, write lands on the ack edge
      st_next.ack = wb_cyc_i & wb_stb_i & ~st_reg.ack;
      unique case (wb_adr_i)
         A_STAT: st_next.rdat = 32'(cnt) | (32'({st_reg.fall_through_mode, st_reg.serial,
                                st_reg.valid, full, empty}) << STAT_FLAG_LSB);
         A_EOFS: st_next.rdat = 32'(st_reg.eofs);
         A_FOFS: st_next.rdat = 32'(st_reg.fofs);
         default: st_next.rdat = '0;
      endcase
      if (wb_cyc_i & wb_stb_i & wb_we_i & st_reg.ack) begin
         if (wb_adr_i == A_EOFS) begin
            st_next.eofs = wb_merge(st_reg.eofs, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == A_FOFS) begin
            st_next.fofs = wb_merge(st_reg.fofs, wb_dat_i, wb_sel_i);
         end
      end

      // Resets: full beats pointer; both beat pointer, read and step updates above, only full beats offsets
      if (in_reset) begin
         st_next.wptr = '0; // [RULE17] [RULE20]
         st_next.rptr = '0;
         st_next.dout = '0; // [RULE23]
         st_next.valid = 1'b0;
         st_next.retx = 1'b0;
         st_next.ft_cnt = '0;
         st_next.wstep = '0;
         st_next.rstep = '0;
      end
      if (!sp.full_reset_n) begin
         st_next.fall_through_mode = sp.mode_select_serial_in; // [RULE9]
         st_next.serial = ~sp.offset_access_n; // [RULE18]
         st_next.eofs = sp.offset_access_n ? OW'(OFS_SHORT) : OW'(OFS_LONG); // [RULE13]
         st_next.fofs = sp.offset_access_n ? OW'(OFS_SHORT) : OW'(OFS_LONG); // [RULE19]
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
         st_reg.s1 <= PINS_IDLE;
         st_reg.s2 <= PINS_IDLE;
         st_reg.eofs <= OW'(OFS_SHORT);
         st_reg.fofs <= OW'(OFS_SHORT);
         st_reg.oe_n <= 1'b1;
         st_reg.fir <= 1'b1;
         st_reg.hf_n <= 1'b1;
         st_reg.paf_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign read_data_out = st_reg.dout;
   assign read_data_oe_n = st_reg.oe_n;
   assign empty_or_out_ready = st_reg.eor;
   assign full_or_in_ready = st_reg.fir;
   assign half_level_flag_n = st_reg.hf_n;
   assign near_empty_flag_n = st_reg.pae_n;
   assign near_full_flag_n = st_reg.paf_n;
   assign wb_dat_o = st_reg.rdat;
   assign wb_ack_o = st_reg.ack;

   // -------------------------------------------------------
   // Assertions
   // -------------------------------------------------------
   a_full_reset_ptrs: assert property (@(posedge clk) disable iff (!reset_n) // [RULE17]
      !sp.full_reset_n |=> st_reg.wptr == '0 && st_reg.rptr == '0)
      else $error("pointers not cleared by full reset");
   a_mode_capture: assert property (@(posedge clk) disable iff (!reset_n) // [RULE9]
      !sp.full_reset_n |=> st_reg.fall_through_mode == $past(sp.mode_select_serial_in))
      else $error("mode not captured at full reset");
   a_ptr_reset_keeps: assert property (@(posedge clk) disable iff (!reset_n) // [RULE20]
      sp.full_reset_n && !sp.pointer_reset_n |=> $stable(st_reg.fall_through_mode) && $stable(st_reg.serial))
      else $error("pointer reset changed settings");
   a_reset_out_zero: assert property (@(posedge clk) disable iff (!reset_n) // [RULE23]
      in_reset |=> st_reg.dout == '0 ##1 !in_reset || st_reg.dout == '0)
      else $error("output register not cleared");
   a_no_overrun: assert property (@(posedge clk) disable iff (!reset_n) // [RULE26]
      wrise && full && !in_reset |=> st_reg.wptr == $past(st_reg.wptr))
      else $error("write accepted while full");
   a_std_read: assert property (@(posedge clk) disable iff (!reset_n) // [RULE6]
      !st_reg.fall_through_mode && rrise && !sp.read_en_n && sp.offset_access_n && sp.rewind_read_n
      && !empty && !in_reset |=> st_reg.dout == $past(mem_rd)
      && st_reg.rptr == $past(st_reg.rptr) + 1'b1)
      else $error("standard read did not advance");
   a_fall_first: assert property (@(posedge clk) disable iff (!reset_n) // [RULE7]
      st_reg.fall_through_mode && !st_reg.valid && !empty && rtog && sp.rewind_read_n
      && sp.offset_access_n && !in_reset
      && st_reg.ft_cnt == 3'(FT_TRANS-1) |=> st_reg.valid ##2 !st_reg.eor || in_reset)
      else $error("first word did not fall through");
   a_rewind_empty: assert property (@(posedge clk) disable iff (!reset_n) // [RULE21]
      rrise && !sp.rewind_read_n && !in_reset |=> st_reg.rptr == '0
      ##1 st_reg.eor == st_reg.fall_through_mode)
      else $error("rewind did not reset read side");
   a_near_empty: assert property (@(posedge clk) disable iff (!reset_n) // [RULE25]
      cnt < {1'b0, st_reg.eofs} |=> !near_empty_flag_n)
      else $error("near empty flag not low");
endmodule

/* File: dcf_pkg.sv */
// Constants, pin bundle and register map of the flagged dual-rate FIFO.
// Assumes one system clock; both FIFO clocks arrive as sampled pins.
package dcf_pkg;
   // -------------------------------------------------------
   // Geometry and defaults
   // -------------------------------------------------------
   localparam int DATA_W = 9;
   // 18 gives 262,144 words, 19 gives 524,288 words
   localparam int DEPTH_LOG2_DEF = 18;
   localparam int OFS_SHORT = 127;
   localparam int OFS_LONG = 1023;
   localparam int FT_TRANS = 3;
   // -------------------------------------------------------
   // Register map
   // -------------------------------------------------------
   localparam logic [3:0] A_STAT = 4'h0;
   localparam logic [3:0] A_EOFS = 4'h4;
   localparam logic [3:0] A_FOFS = 4'h8;
   localparam int STAT_FLAG_LSB = 24;
   localparam int BYTE_W = 8;
   localparam int BUS_BYTES = 4;
   // -------------------------------------------------------
   // Pin bundle, sampled as one vector
   // -------------------------------------------------------
   typedef struct packed {
      logic wclk;
      logic rclk;
      logic write_en_n;
      logic read_en_n;
      logic full_reset_n;
      logic pointer_reset_n;
      logic rewind_read_n;
      logic mode_select_serial_in;
      logic offset_access_n;
      logic serial_load_enable_n;
      logic out_en_n;
      logic [DATA_W-1:0] write_data_in;
   } dcf_pins_t;
endpackage

/* File: dcf_partner.sv */
// Producer and consumer logic on the pin side of the FIFO.
// Assumes clk is the system clock; pin clocks stand still between transfers.
`timescale 1ns/1ns
module dcf_partner (
   input wire logic clk,
   input wire logic [dcf_pkg::DATA_W-1:0] read_data_out,
   output logic wclk,
   output logic rclk,
   output logic write_en_n,
   output logic read_en_n,
   output logic [dcf_pkg::DATA_W-1:0] write_data_in
);
   import dcf_pkg::*;
   initial begin
      wclk = 1'b0;
      rclk = 1'b0;
      write_en_n = 1'b1;
      read_en_n = 1'b1;
      write_data_in = '0;
   end
   // -------------------------------------------------------
   // Write side
   // -------------------------------------------------------
   // Inputs held 4 clk either side of the rise; the sampler needs 3
   task automatic push(input logic [DATA_W-1:0] d);
      @(posedge clk);
      write_en_n <= 1'b0;
      write_data_in <= d;
      repeat (4) @(posedge clk);
      wclk <= 1'b1;
      repeat (4) @(posedge clk);
      wclk <= 1'b0;
      write_en_n <= 1'b1;
      // Released bus shows the inverse, never the stale word
      write_data_in <= ~d;
      repeat (3) @(posedge clk);
   endtask
   // -------------------------------------------------------
   // Read side
   // -------------------------------------------------------
   // One rise and one fall; output taken well after its update
   task automatic pulse_r(input logic en_n, output logic [DATA_W-1:0] q);
      @(posedge clk);
      read_en_n <= en_n;
      repeat (4) @(posedge clk);
      rclk <= 1'b1;
      repeat (6) @(posedge clk);
      q = read_data_out;
      rclk <= 1'b0;
      read_en_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
endmodule

/* File: test_dual_clock_fifo_with_flags.sv */
// Self-checking bench: pins through the partner model, status over Wishbone.
// Assumes a 125 MHz clk; depth cut to 256 words so a fill stays short.
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_dual_clock_fifo_with_flags;
   import dcf_pkg::*;
   localparam int DL2 = 8;
   localparam int DEPTH = 1 << DL2;
   // Serial image: full offset in the upper half, empty offset in the lower
   localparam logic [2*DL2-1:0] SER_PAT = 16'h9c21;
   typedef struct packed {
      logic [DATA_W-1:0] din;
      logic [DATA_W-1:0] q;
   } dcf_row_t;
   dcf_row_t rows [4] = '{'{9'h000, 9'h000}, '{9'h1ff, 9'h1ff}, '{9'h155, 9'h155},
      '{9'h0aa, 9'h0aa}};
   logic clk, reset_n, wclk, rclk, write_en_n, read_en_n, full_reset_n, pointer_reset_n;
   logic rewind_read_n, mode_select_serial_in, offset_access_n, serial_load_enable_n, out_en_n;
   logic [DATA_W-1:0] write_data_in, read_data_out, q;
   logic read_data_oe_n, empty_or_out_ready, full_or_in_ready, half_level_flag_n;
   logic near_empty_flag_n, near_full_flag_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   int miscompares, comparisons, i;
   dcf_fifo #(.DEPTH_LOG2(DL2)) u_dcf_fifo (.clk(clk), .reset_n(reset_n), .wclk(wclk),
      .rclk(rclk), .write_en_n(write_en_n), .read_en_n(read_en_n),
      .full_reset_n(full_reset_n), .pointer_reset_n(pointer_reset_n),
      .rewind_read_n(rewind_read_n), .mode_select_serial_in(mode_select_serial_in),
      .offset_access_n(offset_access_n), .serial_load_enable_n(serial_load_enable_n),
      .out_en_n(out_en_n), .write_data_in(write_data_in), .read_data_out(read_data_out),
      .read_data_oe_n(read_data_oe_n), .empty_or_out_ready(empty_or_out_ready),
      .full_or_in_ready(full_or_in_ready), .half_level_flag_n(half_level_flag_n),
      .near_empty_flag_n(near_empty_flag_n), .near_full_flag_n(near_full_flag_n),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   dcf_partner u_dcf_partner (.clk(clk), .read_data_out(read_data_out), .wclk(wclk),
      .rclk(rclk), .write_en_n(write_en_n), .read_en_n(read_en_n),
      .write_data_in(write_data_in));
   always #4 clk = ~clk;
   // -------------------------------------------------------
   // Tasks
   // -------------------------------------------------------
   task automatic test_done();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
      int n;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (wb_ack_o === 1'b1) break;
      end
      if (n == 20) begin
         miscompares++;
         test_done();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   // Pin resets act two clk late; hold low four, settle six
   task automatic rst(input logic full, input logic fall_through_mode);
      @(posedge clk);
      mode_select_serial_in <= fall_through_mode;
      if (full) full_reset_n <= 1'b0;
      else pointer_reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      full_reset_n <= 1'b1;
      pointer_reset_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   // -------------------------------------------------------
   // Sequence
   // -------------------------------------------------------
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      test_done();
   end
   initial begin
      {clk, reset_n, full_reset_n, mode_select_serial_in, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
      {pointer_reset_n, rewind_read_n, offset_access_n, serial_load_enable_n} = 4'hf;
      {out_en_n, wb_adr_i, wb_dat_i, miscompares, comparisons} = '0;
      wb_sel_i = 4'hf;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rst(1'b1, 1'b0);
      `CHK(empty_or_out_ready, 1'b0)
      `CHK(full_or_in_ready, 1'b1)
      `CHK({half_level_flag_n, near_empty_flag_n, near_full_flag_n}, 3'b101)
      `CHK(read_data_out, 9'h000)
      wb(1'b0, A_EOFS, 32'h0);
      `CHK(rd, 32'(OFS_SHORT))
      wb(1'b0, A_STAT, 32'h0);
      `CHK(rd[28:24], 5'b00001)
      $display("test reset done");
      foreach (rows[k]) u_dcf_partner.push(rows[k].din);
      repeat (6) @(posedge clk);
      `CHK(read_data_out, 9'h000)
      foreach (rows[k]) begin
         u_dcf_partner.pulse_r(1'b0, q);
         `CHK(q, rows[k].q)
      end
      $display("test table done");
      for (i = 1; i <= DEPTH; i++) begin
         u_dcf_partner.push(DATA_W'(i - 1));
         repeat (6) @(posedge clk);
         `CHK(near_empty_flag_n, i >= OFS_SHORT)
         `CHK(near_full_flag_n, i <= DEPTH - OFS_SHORT)
         `CHK(half_level_flag_n, i <= DEPTH / 2)
         `CHK(full_or_in_ready, i != DEPTH)
         `CHK(empty_or_out_ready, 1'b1)
      end
      u_dcf_partner.push(9'h1ff);
      wb(1'b0, A_STAT, 32'h0);
      `CHK(rd[19:0], 20'(DEPTH))
      u_dcf_partner.pulse_r(1'b0, q);
      `CHK(q, 9'h000)
      rst(1'b0, 1'b0);
      `CHK({empty_or_out_ready, full_or_in_ready, read_data_out}, 11'h200)
      wb(1'b0, A_EOFS, 32'h0);
      `CHK(rd, 32'(OFS_SHORT))
      $display("test fill done");
      @(posedge clk);
      offset_access_n <= 1'b0;
      u_dcf_partner.push(9'h005);
      u_dcf_partner.push(9'h0c8);
      u_dcf_partner.pulse_r(1'b0, q);
      `CHK(q, 9'h005)
      u_dcf_partner.pulse_r(1'b0, q);
      `CHK(q, 9'h0c8)
      offset_access_n <= 1'b1;
      wb(1'b0, A_FOFS, 32'h0);
      `CHK(rd, 32'h0000_00c8)
      for (i = 1; i <= 5; i++) begin
         u_dcf_partner.push(DATA_W'(9'h0a0 + i));
         repeat (6) @(posedge clk);
         `CHK(near_empty_flag_n, i >= 5)
      end
      wb(1'b1, A_FOFS, 32'h0000_0010);
      wb(1'b0, A_FOFS, 32'h0);
      `CHK(rd, 32'h0000_0010)
      wb(1'b0, 4'hc, 32'h0);
      `CHK(rd, 32'h0)
      $display("test offsets done");
      u_dcf_partner.pulse_r(1'b0, q);
      u_dcf_partner.pulse_r(1'b0, q);
      `CHK(q, 9'h0a2)
      rewind_read_n <= 1'b0;
      u_dcf_partner.pulse_r(1'b1, q);
      `CHK(empty_or_out_ready, 1'b0)
      rewind_read_n <= 1'b1;
      u_dcf_partner.pulse_r(1'b1, q);
      u_dcf_partner.pulse_r(1'b0, q);
      `CHK(q, 9'h0a1)
      out_en_n <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK(read_data_oe_n, 1'b1)
      out_en_n <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK(read_data_oe_n, 1'b0)
      $display("test rewind done");
      rst(1'b1, 1'b1);
      `CHK({empty_or_out_ready, full_or_in_ready}, 2'b10)
      u_dcf_partner.push(9'h123);
      u_dcf_partner.push(9'h0ee);
      u_dcf_partner.pulse_r(1'b1, q);
      u_dcf_partner.pulse_r(1'b1, q);
      `CHK(q, 9'h123)
      `CHK(empty_or_out_ready, 1'b0)
      u_dcf_partner.pulse_r(1'b0, q);
      `CHK(q, 9'h0ee)
      wb(1'b0, A_STAT, 32'h0);
      `CHK(rd[28], 1'b1)
      $display("test fall-through done");
      offset_access_n <= 1'b0;
      rst(1'b1, 1'b0);
      wb(1'b0, A_EOFS, 32'h0);
      `CHK(rd, 32'(OFS_LONG % DEPTH))
      wb(1'b0, A_STAT, 32'h0);
      `CHK(rd[28:27], 2'b01)
      serial_load_enable_n <= 1'b0;
      for (i = 0; i < 2 * DL2; i++) begin
         mode_select_serial_in <= SER_PAT[i];
         u_dcf_partner.push(9'h000);
      end
      serial_load_enable_n <= 1'b1;
      offset_access_n <= 1'b1;
      wb(1'b0, A_EOFS, 32'h0);
      `CHK(rd, 32'(SER_PAT[DL2-1:0]))
      wb(1'b0, A_FOFS, 32'h0);
      `CHK(rd, 32'(SER_PAT[2*DL2-1:DL2]))
      $display("test serial done");
      reset_n <= 1'b0;
      @(posedge clk);
      `CHK({read_data_oe_n, full_or_in_ready, half_level_flag_n}, 3'b111)
      `CHK({empty_or_out_ready, near_empty_flag_n, near_full_flag_n}, 3'b001)
      `CHK(read_data_out, 9'h000)
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      wb(1'b0, A_EOFS, 32'h0);
      `CHK(rd, 32'(OFS_SHORT))
      wb(1'b0, A_STAT, 32'h0);
      `CHK(rd[28:24], 5'b00001)
      $display("test mid-run reset done");
      test_done();
   end
endmodule
